// ---- design/efrs_top.v ----
/*
 Enable filter and rail sequencer top: deglitched wake input, enable
 events, trigger configuration, simplified device state and rail order.
 Assumes rail valid/undervoltage comparator flags as synchronous inputs
 and a microcontroller that services the event flag through plain ports.
*/
`timescale 1ns/1ps
`default_nettype none
`include "efrs_map.vh"

module efrs_top (
	input wire i_clk,
	input wire i_nrst,
	input wire i_wake_enable_input,
	input wire i_cfg_write,
	input wire i_cfg_enable_trigger_select,
	input wire i_cfg_stg_response,
	input wire i_device_control_request,
	input wire i_event_clear,
	input wire i_fault,
	input wire [3:0] i_rail_valid,
	input wire [3:0] i_rail_above_uv,
	input wire i_ext_rail_enable_in_one,
	input wire i_ext_rail_enable_in_two,
	output reg o_enable_level_status,
	output reg o_enable_event_flag,
	output reg o_enable_trigger_select,
	output reg [1:0] o_device_state,
	output reg o_primary_buck_rail,
	output reg o_secondary_buck_rail,
	output reg o_boost_rail,
	output wire o_ext_rail_enable_out_one,
	output wire o_ext_rail_enable_out_two,
	output wire o_ext_rail_enable_oe_n_one,
	output wire o_ext_rail_enable_oe_n_two,
	output reg o_ext_monitor_one_present,
	output reg o_ext_monitor_two_present,
	output reg [3:0] o_uv_event,
	output reg [3:0] o_ov_monitor_active,
	output reg o_stg_fault,
	output reg o_seq_done
);
	localparam [1:0] ST_DISABLED = 2'h0;
	localparam [1:0] ST_ACTIVE = 2'h1;
	localparam [1:0] ST_FAULT = 2'h2;
	localparam [1:0] ST_LOCKED = 2'h3;

	localparam [2:0] SQ_IDLE = 3'h0;
	localparam [2:0] SQ_PRIMARY_BUCK_RAIL = 3'h1;
	localparam [2:0] SQ_POST = 3'h2;
	localparam [2:0] SQ_VM1 = 3'h3;
	localparam [2:0] SQ_VM2 = 3'h4;
	localparam [2:0] SQ_DONE = 3'h5;
	localparam [2:0] SQ_DETECT = 3'h6;

	localparam [19:0] BUCK_RISE = `EFRS_BUCK_RISE_CYC;
	localparam [19:0] BOOST_RISE = `EFRS_BOOST_RISE_CYC;
	localparam [19:0] STG_CYC = `EFRS_STG_CYC;

	// Stages in which the stage timer runs and a timeout counts
	function in_stage;
		input [2:0] s;
		begin
			in_stage = (s == SQ_PRIMARY_BUCK_RAIL) || (s == SQ_POST) || (s == SQ_VM1) || (s == SQ_VM2);
		end
	endfunction

	// A rail stays on from its own stage to the end of the sequence
	function rail_from;
		input [2:0] s;
		input [2:0] first;
		begin
			rail_from = (s >= first) && (s <= SQ_DONE);
		end
	endfunction

	// A timeout moves the sequence on only when the response is to continue
	function timeout_skip;
		input t;
		input resp;
		begin
			timeout_skip = t && (resp == `EFRS_STG_RESP_CONT);
		end
	endfunction

	wire ena_level;
	wire ena_rise;
	wire ena_fall;
	wire rise_done;
	wire timeout;

	reg [2:0] seq_reg;
	reg [2:0] seq_next;
	reg stage_start;
	reg [1:0] fault_cnt_reg;
	reg [3:0] uv_armed_reg;
	reg ext_drive_reg;
	reg [19:0] rise_sel;
	reg stage_ok;

	efrs_deglitch u_deglitch (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_raw(i_wake_enable_input),
		.o_level(ena_level),
		.o_rise(ena_rise),
		.o_fall(ena_fall)
	);

	efrs_rise_timer u_timer (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_start(stage_start),
		.i_run(in_stage(seq_reg)),
		.i_rise_cyc(rise_sel),
		.i_stg_cyc(STG_CYC),
		.o_rise_done(rise_done),
		.o_timeout(timeout)
	);

	// Event flag: set wins over clear
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_enable_level_status <= 1'h0;
			o_enable_event_flag <= 1'h0;
		end else begin
			o_enable_level_status <= ena_level;
			if (ena_rise || ena_fall) begin
				o_enable_event_flag <= 1'h1;
			end else if (i_event_clear) begin
				o_enable_event_flag <= 1'h0;
			end
		end
	end

	// Trigger select; a software disable request reverts it to default
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_enable_trigger_select <= `EFRS_CFG_TRIG_RST;
		end else if (i_device_control_request) begin
			o_enable_trigger_select <= `EFRS_CFG_TRIG_RST;
		end else if (i_cfg_write) begin
			o_enable_trigger_select <= i_cfg_enable_trigger_select;
		end
	end

	// Device state; falling events never leave ACTIVE on their own
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_device_state <= ST_DISABLED;
			fault_cnt_reg <= 2'h0;
		end else begin
			case (o_device_state)
				ST_DISABLED: begin
					// Only a rising event wakes, whatever the mode
					if (ena_rise) begin
						o_device_state <= ST_ACTIVE;
					end
				end
				ST_ACTIVE: begin
					if (i_device_control_request) begin
						o_device_state <= ST_DISABLED;
						fault_cnt_reg <= 2'h0;
					end else if (i_fault || (o_stg_fault && i_cfg_stg_response == `EFRS_STG_RESP_FAULT)) begin
						o_device_state <= ST_FAULT;
						if (fault_cnt_reg != `EFRS_FAULT_LOCK_N) begin
							fault_cnt_reg <= fault_cnt_reg + 2'h1;
						end
					end else if (seq_reg == SQ_DONE) begin
						fault_cnt_reg <= 2'h0;
					end
				end
				ST_FAULT: begin
					if (o_enable_trigger_select == `EFRS_TRIG_LEVEL && ena_level) begin
						o_device_state <= ST_ACTIVE;
					end else if (fault_cnt_reg == `EFRS_FAULT_LOCK_N) begin
						o_device_state <= ST_LOCKED;
					end else if (ena_rise) begin
						o_device_state <= ST_ACTIVE;
					end
				end
				ST_LOCKED: begin
					o_device_state <= ST_LOCKED;
				end
				default: begin
					o_device_state <= ST_DISABLED;
				end
			endcase
		end
	end

	// Use detection: try to drive the external enables high once after reset
	assign o_ext_rail_enable_out_one = ext_drive_reg | (o_ext_monitor_one_present && rail_from(seq_reg, SQ_VM1) &&
		o_device_state == ST_ACTIVE);
	assign o_ext_rail_enable_out_two = ext_drive_reg | (o_ext_monitor_two_present && rail_from(seq_reg, SQ_VM2) &&
		o_device_state == ST_ACTIVE);
	assign o_ext_rail_enable_oe_n_one = 1'h0;
	assign o_ext_rail_enable_oe_n_two = 1'h0;

	always @* begin
		case (seq_reg)
			SQ_POST: rise_sel = BOOST_RISE;
			SQ_PRIMARY_BUCK_RAIL: rise_sel = BUCK_RISE;
			default: rise_sel = 20'h00001;
		endcase
		case (seq_reg)
			SQ_PRIMARY_BUCK_RAIL: stage_ok = i_rail_valid[0];
			SQ_POST: stage_ok = i_rail_valid[1] && i_rail_valid[2];
			SQ_VM1: stage_ok = i_rail_valid[3];
			SQ_VM2: stage_ok = i_rail_valid[3];
			default: stage_ok = 1'h0;
		endcase
	end

	always @* begin
		seq_next = seq_reg;
		case (seq_reg)
			SQ_DETECT: seq_next = SQ_IDLE;
			SQ_IDLE: begin
				if (o_device_state == ST_ACTIVE) begin
					seq_next = SQ_PRIMARY_BUCK_RAIL;
				end
			end
			SQ_PRIMARY_BUCK_RAIL, SQ_POST: begin
				if ((stage_ok && rise_done) || timeout_skip(timeout, i_cfg_stg_response)) begin
					seq_next = seq_reg + 3'h1;
				end
			end
			SQ_VM1: begin
				if (!o_ext_monitor_one_present || stage_ok || timeout_skip(timeout, i_cfg_stg_response)) begin
					seq_next = SQ_VM2;
				end
			end
			SQ_VM2: begin
				if (!o_ext_monitor_two_present || stage_ok || timeout_skip(timeout, i_cfg_stg_response)) begin
					seq_next = SQ_DONE;
				end
			end
			SQ_DONE: seq_next = SQ_DONE;
			default: seq_next = SQ_IDLE;
		endcase
		if (seq_reg != SQ_DETECT && o_device_state != ST_ACTIVE) begin
			seq_next = SQ_IDLE;
		end
		// Restart on the entry edge itself, so a new stage never sees the old count
		stage_start = (seq_next != seq_reg);
	end

	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			seq_reg <= SQ_DETECT;
			ext_drive_reg <= 1'h1;
			o_ext_monitor_one_present <= 1'h0;
			o_ext_monitor_two_present <= 1'h0;
			o_primary_buck_rail <= 1'h0;
			o_secondary_buck_rail <= 1'h0;
			o_boost_rail <= 1'h0;
			o_uv_event <= 4'h0;
			uv_armed_reg <= 4'h0;
			o_ov_monitor_active <= 4'h0;
			o_stg_fault <= 1'h0;
			o_seq_done <= 1'h0;
		end else begin
			seq_reg <= seq_next;
			if (seq_reg == SQ_DETECT) begin
				ext_drive_reg <= 1'h0;
				o_ext_monitor_one_present <= i_ext_rail_enable_in_one;
				o_ext_monitor_two_present <= i_ext_rail_enable_in_two;
			end
			o_primary_buck_rail <= rail_from(seq_next, SQ_PRIMARY_BUCK_RAIL);
			o_secondary_buck_rail <= rail_from(seq_next, SQ_POST);
			o_boost_rail <= rail_from(seq_next, SQ_POST);
			// Bit order follows the valid inputs; the detect drive is no real enable
			o_ov_monitor_active <= {(o_ext_rail_enable_out_one | o_ext_rail_enable_out_two) & ~ext_drive_reg,
				o_boost_rail, o_secondary_buck_rail, o_primary_buck_rail};
			uv_armed_reg <= (uv_armed_reg | (i_rail_above_uv & o_ov_monitor_active)) & o_ov_monitor_active;
			o_uv_event <= uv_armed_reg & ~i_rail_above_uv & o_ov_monitor_active;
			if (in_stage(seq_reg) && timeout && !stage_ok) begin
				o_stg_fault <= 1'h1;
			end else if (seq_reg == SQ_IDLE) begin
				o_stg_fault <= 1'h0;
			end
			o_seq_done <= (seq_next == SQ_DONE);
		end
	end
endmodule
`default_nettype wire

// ---- design/efrs_map.vh ----
/*
 Constants for the enable filter and rail sequencer: timing figures,
 derived cycle counts, mode and response codes.
 Assumes a 100 MHz system clock.
*/
`ifndef EFRS_MAP_VH
`define EFRS_MAP_VH

`define EFRS_CLK_MHZ 100
`define EFRS_FILT_US 20
`define EFRS_DET_US 40
// Cycle counts at EFRS_CLK_MHZ, sized to the 20-bit counters that compare them
// Detection time is a least time: whole cycles, no rounding needed at 100 MHz
`define EFRS_DET_CYC 20'h00FA0
`define EFRS_FILT_CYC 20'h007D0
`define EFRS_BUCK_RISE_US 320
`define EFRS_BOOST_RISE_US 640
`define EFRS_BUCK_RISE_CYC 20'h07D00
`define EFRS_BOOST_RISE_CYC 20'h0FA00
`define EFRS_STG_US 2000
`define EFRS_STG_CYC 20'h30D40
`define EFRS_CNT_W 20

`define EFRS_TRIG_EDGE 1'h0
`define EFRS_TRIG_LEVEL 1'h1
`define EFRS_CFG_TRIG_RST 1'h0

`define EFRS_STG_RESP_CONT 1'h0
`define EFRS_STG_RESP_FAULT 1'h1

`define EFRS_FAULT_LOCK_N 2'h3

`endif

// ---- design/efrs_deglitch.v ----
/*
 Enable input deglitch: two-stage synchroniser followed by a run counter
 that restarts on every raw level change.
 Assumes the comparator output arrives as a plain digital input.
*/
`timescale 1ns/1ps
`default_nettype none
`include "efrs_map.vh"

module efrs_deglitch #(
	parameter [19:0] DET_CYC = `EFRS_DET_CYC
) (
	input wire i_clk,
	input wire i_nrst,
	input wire i_raw,
	output reg o_level,
	output reg o_rise,
	output reg o_fall
);
	reg sync1_reg;
	reg sync2_reg;
	reg last_reg;
	reg [19:0] run_reg;

	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			sync1_reg <= 1'h0;
			sync2_reg <= 1'h0;
			last_reg <= 1'h0;
			run_reg <= 20'h00000;
			o_level <= 1'h0;
			o_rise <= 1'h0;
			o_fall <= 1'h0;
		end else begin
			sync1_reg <= i_raw;
			sync2_reg <= sync1_reg;
			last_reg <= sync2_reg;
			o_rise <= 1'h0;
			o_fall <= 1'h0;
			// Restart the run on every level change, so short excursions never qualify
			if (sync2_reg != last_reg) begin
				run_reg <= 20'h00000;
			end else if (sync2_reg != o_level) begin
				if (run_reg >= DET_CYC - 20'h00002) begin
					o_level <= sync2_reg;
					o_rise <= sync2_reg;
					o_fall <= ~sync2_reg;
					run_reg <= 20'h00000;
				end else begin
					run_reg <= run_reg + 20'h00001;
				end
			end else begin
				run_reg <= 20'h00000;
			end
		end
	end
endmodule
`default_nettype wire

// ---- design/efrs_rise_timer.v ----
/*
 Per-stage timer for the rail sequencer: counts rise time and the
 short-to-ground timeout from the stage start.
 Assumes i_start is high in the cycle that leads into a new stage.
*/
`timescale 1ns/1ps
`default_nettype none
`include "efrs_map.vh"

module efrs_rise_timer (
	input wire i_clk,
	input wire i_nrst,
	input wire i_start,
	input wire i_run,
	input wire [19:0] i_rise_cyc,
	input wire [19:0] i_stg_cyc,
	output wire o_rise_done,
	output wire o_timeout
);
	reg [19:0] cnt_reg;

	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cnt_reg <= 20'h00000;
		end else if (i_start) begin
			cnt_reg <= 20'h00000;
		end else if (i_run && cnt_reg != 20'hFFFFF) begin
			cnt_reg <= cnt_reg + 20'h00001;
		end
	end

	assign o_rise_done = (cnt_reg >= i_rise_cyc);
	assign o_timeout = (cnt_reg >= i_stg_cyc);
endmodule
`default_nettype wire

// ---- verification/efrs_top_asserts.sv ----
/* Concurrent checks on the efrs_top ports, bound after the module.
 Assumes one 100 MHz clock and an asynchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module efrs_top_asserts (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_wake_enable_input,
	input wire logic i_device_control_request,
	input wire logic i_event_clear,
	input wire logic i_fault,
	input wire logic o_enable_level_status,
	input wire logic o_enable_event_flag,
	input wire logic o_enable_trigger_select,
	input wire logic [1:0] o_device_state,
	input wire logic o_primary_buck_rail,
	input wire logic o_secondary_buck_rail,
	input wire logic o_boost_rail,
	input wire logic [3:0] o_ov_monitor_active
);
	logic raw_reg;
	logic [19:0] run_reg;
	logic [19:0] up_reg;
	// Saturating, so long idle spans cannot wrap into a false short run
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			raw_reg <= 1'h0;
			run_reg <= 20'h0;
			up_reg <= 20'h0;
		end else begin
			raw_reg <= i_wake_enable_input;
			run_reg <= (i_wake_enable_input != raw_reg) ? 20'h0 : run_reg + {19'h0, ~&run_reg};
			up_reg <= !o_primary_buck_rail ? 20'h0 : up_reg + {19'h0, ~&up_reg};
		end
	end
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_nrst);
	property p_filt_run;
		$changed(o_enable_level_status) |-> run_reg >= 20'h00FA0 && o_enable_level_status == raw_reg;
	endproperty
	a_filt_run: assert property (p_filt_run) else $error("level changed without a stable run");
	property p_flag_rise;
		$rose(o_enable_level_status) |-> o_enable_event_flag;
	endproperty
	a_flag_rise: assert property (p_flag_rise) else $error("no event on rising level");
	property p_flag_hold;
		o_enable_event_flag && !i_event_clear |=> o_enable_event_flag;
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("event flag lost");
	property p_no_self_off;
		o_device_state == 2'h1 && !i_device_control_request && !i_fault |=> o_device_state != 2'h0;
	endproperty
	a_no_self_off: assert property (p_no_self_off) else $error("device disabled itself");
	property p_cfg_revert;
		o_device_state == 2'h1 && i_device_control_request |-> ##[1:2] (o_device_state == 2'h0 && !o_enable_trigger_select);
	endproperty
	a_cfg_revert: assert property (p_cfg_revert) else $error("config kept after disable");
	property p_order;
		$rose(o_secondary_buck_rail) |-> o_primary_buck_rail && up_reg >= 20'h07D00;
	endproperty
	a_order: assert property (p_order) else $error("post rails early");
	property p_pair;
		o_secondary_buck_rail == o_boost_rail;
	endproperty
	a_pair: assert property (p_pair) else $error("post rails split");
	property p_drop;
		o_device_state != 2'h1 [*2] |-> !o_primary_buck_rail && !o_secondary_buck_rail;
	endproperty
	a_drop: assert property (p_drop) else $error("rail on outside active");
	property p_ov;
		$rose(o_primary_buck_rail) |-> ##[0:1] o_ov_monitor_active[0];
	endproperty
	a_ov: assert property (p_ov) else $error("overvoltage monitor off");
	c_level: cover property ($rose(o_enable_level_status));
	c_post: cover property ($rose(o_secondary_buck_rail));
	c_req: cover property (o_device_state == 2'h1 && i_device_control_request);
endmodule
bind efrs_top efrs_top_asserts u_chk (.i_clk, .i_nrst, .i_wake_enable_input, .i_device_control_request,
	.i_event_clear, .i_fault, .o_enable_level_status, .o_enable_event_flag, .o_enable_trigger_select,
	.o_device_state, .o_primary_buck_rail, .o_secondary_buck_rail, .o_boost_rail, .o_ov_monitor_active);
`default_nettype wire

// ---- verification/efrs_rail_model.sv ----
/* Rail comparators and external enable pins seen by the sequencer.
 Assumes enables from efrs_top; monitor two has its pin grounded. */
`timescale 1ns/1ps
`default_nettype none
module efrs_rail_model #(
	parameter int DLY = 1000
) (
	input wire logic i_clk,
	input wire logic [3:0] i_en,
	output logic [3:0] o_valid,
	output logic o_pin_one,
	output logic o_pin_two
);
	int cnt [4];
	// A rail dropped reads invalid from the next clock edge, never its old state
	always_ff @(posedge i_clk) begin
		for (int k = 0; k < 4; k++) begin
			cnt[k] <= i_en[k] ? cnt[k] + 1 : 0;
			o_valid[k] <= i_en[k] && cnt[k] >= DLY;
		end
	end
	assign o_pin_one = i_en[3];
	assign o_pin_two = 1'h0;
endmodule
`default_nettype wire

// ---- verification/efrs_top_test.sv ----
/* Self-checking bench for efrs_top with the rail model as far side.
 Assumes the 100 MHz clock and the settle figures of the hand-over. */
`timescale 1ns/1ps
`default_nettype none
module efrs_top_test;
	logic i_clk, i_nrst, wake, cfg_wr, trig_in, req, clr, flt, stg, done;
	logic status, flag, trig, prim, sec, boost, out_one, out_two, pres_one, pres_two, pin_one, pin_two;
	logic [1:0] state;
	logic [3:0] valid, uv, ov;
	int fails, n_checks;
	efrs_top uut (.i_clk(i_clk), .i_nrst(i_nrst), .i_wake_enable_input(wake), .i_cfg_write(cfg_wr),
		.i_cfg_enable_trigger_select(trig_in), .i_cfg_stg_response(1'h0), .i_device_control_request(req),
		.i_event_clear(clr), .i_fault(flt), .i_rail_valid(valid), .i_rail_above_uv(valid),
		.i_ext_rail_enable_in_one(pin_one), .i_ext_rail_enable_in_two(pin_two), .o_enable_level_status(status),
		.o_enable_event_flag(flag), .o_enable_trigger_select(trig), .o_device_state(state),
		.o_primary_buck_rail(prim), .o_secondary_buck_rail(sec), .o_boost_rail(boost),
		.o_ext_rail_enable_out_one(out_one), .o_ext_rail_enable_out_two(out_two),
		.o_ext_rail_enable_oe_n_one(), .o_ext_rail_enable_oe_n_two(), .o_ext_monitor_one_present(pres_one),
		.o_ext_monitor_two_present(pres_two), .o_uv_event(uv), .o_ov_monitor_active(ov), .o_stg_fault(stg),
		.o_seq_done(done));
	efrs_rail_model rails (.i_clk(i_clk), .i_en({out_one | out_two, boost, sec, prim}), .o_valid(valid),
		.o_pin_one(pin_one), .o_pin_two(pin_two));
	task automatic chk(input logic [3:0] got, input logic [3:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic set_wake(input logic v, input int n);
		@(posedge i_clk) wake <= v;
		tick(n);
	endtask
	task automatic clear_flag;
		@(posedge i_clk) clr <= 1'h1;
		@(posedge i_clk) clr <= 1'h0;
		tick(2);
	endtask
	task automatic tally_and_finish;
		if (fails == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		i_clk = 1'h0;
		forever #5 i_clk = ~i_clk;
	end
	initial begin
		repeat (90000) @(posedge i_clk);
		fails++;
		tally_and_finish();
	end
	initial begin
		i_nrst = 1'h0;
		{wake, cfg_wr, trig_in, req, clr, flt} = 6'h00;
		repeat (16) @(posedge i_clk);
		i_nrst <= 1'h1;
		tick(3);
		chk(trig, 1'h0);
		chk(pres_one, 1'h1);
		chk(pres_two, 1'h0);
		set_wake(1'h1, 1500);
		set_wake(1'h0, 5000);
		chk(status, 1'h0);
		chk(flag, 1'h0);
		set_wake(1'h1, 3990);
		chk(status, 1'h0);
		tick(110);
		chk(status, 1'h1);
		chk(flag, 1'h1);
		tick(4);
		chk(state, 2'h1);
		chk(prim, 1'h1);
		chk(sec, 1'h0);
		clear_flag();
		chk(flag, 1'h0);
		set_wake(1'h0, 1500);
		set_wake(1'h1, 5000);
		chk(status, 1'h1);
		for (int k = 0; k < 40000 && sec !== 1'h1; k++) tick(1);
		chk(sec, 1'h1);
		chk(boost, 1'h1);
		chk(out_one, 1'h0);
		set_wake(1'h0, 4100);
		chk(status, 1'h0);
		chk(state, 2'h1);
		chk(out_two, 1'h0);
		chk(ov, 4'h7);
		chk(uv, 4'h0);
		chk(done, 1'h0);
		chk(stg, 1'h0);
		clear_flag();
		@(posedge i_clk) {cfg_wr, trig_in} <= 2'h3;
		@(posedge i_clk) cfg_wr <= 1'h0;
		tick(2);
		chk(trig, 1'h1);
		@(posedge i_clk) req <= 1'h1;
		@(posedge i_clk) req <= 1'h0;
		tick(3);
		chk(state, 2'h0);
		chk(trig, 1'h0);
		chk(prim, 1'h0);
		set_wake(1'h1, 4110);
		chk(flag, 1'h1);
		chk(state, 2'h1);
		@(posedge i_clk) cfg_wr <= 1'h1;
		@(posedge i_clk) cfg_wr <= 1'h0;
		@(posedge i_clk) flt <= 1'h1;
		@(posedge i_clk) flt <= 1'h0;
		tick(0);
		chk(state, 2'h2);
		tick(1);
		chk(state, 2'h1);
		tally_and_finish();
	end
endmodule
`default_nettype wire
